// ==== clock_mode_pkg.sv ====
// Constants and types for the core clock and divider mode selection block.
// Assumes nothing; imported by the top module, the strap model, the checker and the bench.
package clock_mode_pkg;

    // =========================================================
    // Divider select codes on the strap pins
    localparam logic [2:0] DIVSEL_BY1 = 3'h0;
    localparam logic [2:0] DIVSEL_BY2 = 3'h1;
    localparam logic [2:0] DIVSEL_BY4 = 3'h2;
    localparam logic [2:0] DIVSEL_BY6 = 3'h3;
    localparam logic [2:0] DIVSEL_BY8 = 3'h4;

    // =========================================================
    // Divisors and core clock figures
    localparam logic [3:0] DIV_1 = 4'h1;
    localparam logic [3:0] DIV_2 = 4'h2;
    localparam logic [3:0] DIV_4 = 4'h4;
    localparam logic [3:0] DIV_6 = 4'h6;
    localparam logic [3:0] DIV_8 = 4'h8;
    localparam logic [5:0] CORE_MULT = 6'h38;              // 56
    localparam logic [11:0] INSTR_NORMAL = 12'he00;        // 3584
    localparam logic [11:0] INSTR_DUAL = 12'h700;          // 1792
    localparam logic [11:0] INSTR_QUAD = 12'h380;          // 896
    // Divided reference cycles per sample: instructions / multiplier
    localparam logic [6:0] DREF_NORMAL = 7'h40;            // 64
    localparam logic [6:0] DREF_DUAL = 7'h20;              // 32
    localparam logic [6:0] DREF_QUAD = 7'h10;              // 16

    // =========================================================
    // Core rate and output clock configuration
    typedef enum logic [1:0] {
        RATE_NORMAL = 2'h0,
        RATE_DUAL   = 2'h1,
        RATE_QUAD   = 2'h2,
        RATE_BAD    = 2'h3
    } rate_t;

    typedef enum logic [1:0] {
        BUFFERED_REFERENCE_OUT_OFF  = 2'h0,
        BUFFERED_REFERENCE_OUT_REF2 = 2'h1,
        BUFFERED_REFERENCE_OUT_REF4 = 2'h2,
        BUFFERED_REFERENCE_OUT_DIV  = 2'h3
    } buffered_reference_out_mode_t;

    typedef enum logic [1:0] {
        ST_HOLD    = 2'h0,
        ST_CAPTURE = 2'h1,
        ST_RUN     = 2'h3,
        ST_FAULT   = 2'h2
    } state_t;

    // =========================================================
    // Reset values
    localparam logic [3:0] DIV_RESET = 4'h1;
    localparam logic [11:0] INSTR_RESET = 12'h000;

    function automatic logic [3:0] divisor_of(input logic [2:0] code);
        case (code)
            DIVSEL_BY1: divisor_of = DIV_1;
            DIVSEL_BY2: divisor_of = DIV_2;
            DIVSEL_BY4: divisor_of = DIV_4;
            DIVSEL_BY6: divisor_of = DIV_6;
            DIVSEL_BY8: divisor_of = DIV_8;
            default:    divisor_of = 4'h0;
        endcase
    endfunction

    function automatic logic [11:0] instr_of(input rate_t rate);
        case (rate)
            RATE_NORMAL: instr_of = INSTR_NORMAL;
            RATE_DUAL:   instr_of = INSTR_DUAL;
            RATE_QUAD:   instr_of = INSTR_QUAD;
            default:     instr_of = INSTR_RESET;
        endcase
    endfunction

    function automatic logic [6:0] dref_of(input rate_t rate);
        case (rate)
            RATE_NORMAL: dref_of = DREF_NORMAL;
            RATE_DUAL:   dref_of = DREF_DUAL;
            RATE_QUAD:   dref_of = DREF_QUAD;
            default:     dref_of = DREF_NORMAL;
        endcase
    endfunction

endpackage

// ==== reference_divider.sv ====
// Reference divider: one-cycle tick every divisor clocks while enabled.
// Assumes a synchronised active-low reset and a divisor held while enabled.
`timescale 1ns/10ps
module reference_divider #(
    parameter int WIDTH = 4
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // Control
    input  wire logic             enable,
    input  wire logic [WIDTH-1:0] divisor,
    // Result
    output logic                  tick
);
    typedef struct packed {
        logic [WIDTH-1:0] count;
        logic             tick;
    } div_state_t;

    div_state_t cur;
    div_state_t next_cur;

    // =========================================================
    // Counter
    always_comb begin
        next_cur = cur;
        next_cur.tick = 1'b0;
        if (!enable) begin
            next_cur.count = '0;
        end else if (cur.count >= divisor - WIDTH'(1)) begin
            next_cur.count = '0;
            next_cur.tick = 1'b1;
        end else begin
            next_cur.count = cur.count + WIDTH'(1);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign tick = cur.tick;
endmodule

// ==== core_clock_pll_mode_select.sv ====
// Master clock intake, reference division, per-sample core cycle timing
// and buffered reference output. MCLK is the reference clock input.
// Assumes strap pins are static around reset release.
`timescale 1ns/10ps

// Behaviour
// RULE1: Divide reference by 1,2,4,6,8 for codes 000-100; multiply by 56.
// RULE2: Normal rate gives 3584 core cycles per sample.
// RULE3: Dual rate gives 1792 core cycles per sample.
// RULE4: Quad rate gives 896 core cycles per sample.
// RULE5: Master clock input is the only reference for clock generation.
// RULE6: Buffered clock output behaviour set by its configuration pins.
// RULE7: Active-low reset; enter on falling edge, leave on rising edge.
// RULE8: Every reset returns all state to defaults.
// RULE9: Divider code captured at reset release; 101-111 unsupported.
module core_clock_pll_mode_select
    import clock_mode_pkg::*;
(
    // Clock and reset
    input  wire logic                        MCLK,
    input  wire logic                        NRST,
    // Strap and configuration pins
    input  wire logic [2:0]                  DIVIDER_SELECT_PINS,
    input  wire clock_mode_pkg::rate_t       CORE_RATE_SELECT,
    input  wire clock_mode_pkg::buffered_reference_out_mode_t OUTPUT_CLOCK_CONFIG_PINS,
    // Status
    output logic                             LOCKED,
    output logic                             MODE_UNSUPPORTED,
    output logic [3:0]                       DIVISOR,
    output logic [5:0]                       MULTIPLIER,
    output logic [11:0]                      INSTR_PER_SAMPLE,
    // Timing strobes
    output logic                             DIVIDED_REF_TICK,
    output logic                             SAMPLE_TICK,
    // Buffered reference output
    output logic                             BUFFERED_REFERENCE_OUT
);
    import clock_mode_pkg::*;

    typedef struct packed {
        state_t       state;
        rate_t        rate;
        logic [3:0]   divisor;
        logic [6:0]   dref_count;
        logic [1:0]   out_count;
        logic         locked;
        logic         unsupported;
        logic [5:0]   mult;
        logic [11:0]  instr;
        logic         div_tick;
        logic         sample_tick;
        logic         ref_out;
    } top_state_t;

    // =========================================================
    // Register defaults; every reset restores all of them, and the
    // block keeps no memory that could survive one
    localparam top_state_t RESET_STATE = '{
        state:       ST_HOLD,
        rate:        RATE_NORMAL,
        divisor:     DIV_RESET,
        dref_count:  7'h00,
        out_count:   2'h0,
        locked:      1'b0,
        unsupported: 1'b0,
        mult:        6'h00,
        instr:       INSTR_RESET,
        div_tick:    1'b0,
        sample_tick: 1'b0,
        ref_out:     1'b0
    };

    // =========================================================
    // Core cycles per sample over the fixed multiplier gives the
    // divided-reference cycles per sample
    function automatic logic last_dref(
        input logic [6:0] count,
        input rate_t      rate
    );
        last_dref = (count >= dref_of(rate) - 7'h01);
    endfunction

    // =========================================================
    // Strap capture: a code beyond divide-by-8 or the spare rate code
    // is refused, not guessed at; divider and sample timing idle until the next
    // reset, since a wrong core clock would be worse than none
    function automatic top_state_t capture_straps(
        input top_state_t prev,
        input logic [2:0] code,
        input rate_t      rate
    );
        capture_straps = prev;
        capture_straps.rate = rate;
        capture_straps.mult = CORE_MULT;                 // RULE1
        if (divisor_of(code) == 4'h0 || rate == RATE_BAD) begin
            capture_straps.unsupported = 1'b1;           // RULE9
            capture_straps.divisor = DIV_RESET;
            capture_straps.instr = INSTR_RESET;
            capture_straps.state = ST_FAULT;
        end else begin
            capture_straps.divisor = divisor_of(code);   // RULE1
            capture_straps.instr = instr_of(rate);       // RULE2 RULE3 RULE4
            capture_straps.locked = 1'b1;
            capture_straps.state = ST_RUN;
        end
    endfunction

    // =========================================================
    // Buffered output: it can only change at MCLK edges, so MCLK/2 is
    // the fastest setting; mode pins are live, not latched
    function automatic logic clock_out_next(
        input buffered_reference_out_mode_t mode,
        input logic         level,
        input logic         phase,
        input logic         dref_tick
    );
        case (mode)
            BUFFERED_REFERENCE_OUT_OFF:  clock_out_next = 1'b0;
            BUFFERED_REFERENCE_OUT_REF2: clock_out_next = ~level;
            BUFFERED_REFERENCE_OUT_REF4: clock_out_next = phase ? ~level : level;
            BUFFERED_REFERENCE_OUT_DIV:  clock_out_next = dref_tick ? ~level : level;
            default:     clock_out_next = 1'b0;
        endcase
    endfunction

    top_state_t cur;
    top_state_t next_cur;
    logic [1:0] rst_sync;
    logic       rst_n;
    logic       div_tick_raw;

    // =========================================================
    // Reset release through two flip-flops
    // Asserts at once; release lands on a clock edge so no flop
    // sees its reset lift close to MCLK
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            rst_sync <= 2'h0;                            // RULE7
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};             // RULE7
        end
    end
    assign rst_n = rst_sync[1];

    // =========================================================
    // Reference divider, run only once a mode is accepted
    // Held at zero outside RUN so every mode starts from a fresh count
    reference_divider #(
        .WIDTH(4)
    ) u_reference_divider (
        .clk    (MCLK),                                  // RULE5
        .rst_n  (rst_n),
        .enable (cur.state == ST_RUN),
        .divisor(cur.divisor),                           // RULE1
        .tick   (div_tick_raw)
    );

    // =========================================================
    // Mode capture, sample timing and output clock
    always_comb begin
        next_cur = cur;
        next_cur.div_tick = 1'b0;
        next_cur.sample_tick = 1'b0;
        case (cur.state)
            ST_HOLD: begin
                next_cur.state = ST_CAPTURE;
            end
            ST_CAPTURE: begin
                // Straps sampled once, second clock after release
                next_cur = capture_straps(next_cur,
                                          DIVIDER_SELECT_PINS, // RULE9
                                          CORE_RATE_SELECT);
            end
            ST_RUN: begin
                next_cur.div_tick = div_tick_raw;
                if (div_tick_raw) begin
                    // 56 core cycles per divided reference cycle
                    if (last_dref(cur.dref_count, cur.rate)) begin
                        next_cur.dref_count = 7'h00;
                        next_cur.sample_tick = 1'b1;     // RULE2 RULE3 RULE4
                    end else begin
                        next_cur.dref_count = cur.dref_count + 7'h01;
                    end
                end
            end
            ST_FAULT: begin
                // Stays here until the next reset
                next_cur.state = ST_FAULT;
            end
            default: begin
                next_cur.state = ST_HOLD;
            end
        endcase

        next_cur.out_count = cur.out_count + 2'h1;
        next_cur.ref_out = clock_out_next(OUTPUT_CLOCK_CONFIG_PINS,
                                          cur.ref_out, cur.out_count[0],
                                          cur.state == ST_RUN &&
                                          div_tick_raw);        // RULE6
    end

    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            cur <= RESET_STATE;                          // RULE8
        end else begin
            cur <= next_cur;
        end
    end

    // =========================================================
    // Outputs, all straight from the state register
    assign LOCKED = cur.locked;
    assign MODE_UNSUPPORTED = cur.unsupported;
    assign DIVISOR = cur.divisor;
    assign MULTIPLIER = cur.mult;
    assign INSTR_PER_SAMPLE = cur.instr;
    assign DIVIDED_REF_TICK = cur.div_tick;
    assign SAMPLE_TICK = cur.sample_tick;
    assign BUFFERED_REFERENCE_OUT = cur.ref_out;
endmodule

// ==== reset_strap_source.sv ====
// Far-side model: reset driver and strap pins of the board.
// Assumes the bench makes the clock and commands reset by hold.
`timescale 1ns/10ps
module reset_strap_source
    import clock_mode_pkg::*;
(
    // Clock and command
    input  wire logic       clk,
    input  wire logic       hold,
    input  wire logic [2:0] code,
    input  wire rate_t      rate,
    // Board pins
    output logic            nrst,
    output logic [2:0]      div_pins,
    output rate_t           rate_pins
);
    // =========================================
    // Straps only move while reset is held
    always_ff @(negedge clk) begin
        nrst <= !hold;
        if (hold) begin
            div_pins <= code;
            rate_pins <= rate;
        end
    end
endmodule

// ==== clock_mode_checker_checker.sv ====
// Assertions on the core clock block ports.
// Assumes a single MCLK domain; bound below by module name.
`timescale 1ns/10ps
module clock_mode_checker
    import clock_mode_pkg::*;
(
    // Clock and reset
    input wire logic         MCLK,
    input wire logic         NRST,
    // Straps and configuration
    input wire rate_t        CORE_RATE_SELECT,
    input wire buffered_reference_out_mode_t OUTPUT_CLOCK_CONFIG_PINS,
    // Status and strobes
    input wire logic         LOCKED,
    input wire logic         MODE_UNSUPPORTED,
    input wire logic [3:0]   DIVISOR,
    input wire logic [5:0]   MULTIPLIER,
    input wire logic [11:0]  INSTR_PER_SAMPLE,
    input wire logic         DIVIDED_REF_TICK,
    input wire logic         SAMPLE_TICK,
    input wire logic         BUFFERED_REFERENCE_OUT
);
    // =========================================
    // Properties
    default clocking @(posedge MCLK); endclocking
    default disable iff (!NRST);
    sequence s_wait; !(LOCKED || MODE_UNSUPPORTED) [*4]; endsequence
    sequence s_up; LOCKED || MODE_UNSUPPORTED; endsequence
    property p_cap; $rose(NRST) |-> s_wait ##1 s_up; endproperty
    property p_rst; $rose(NRST) |-> DIVISOR == 4'h1 && !LOCKED
        && INSTR_PER_SAMPLE == 12'h000 && MULTIPLIER == 6'h00; endproperty
    property p_norm; $rose(LOCKED) && CORE_RATE_SELECT == RATE_NORMAL
        |-> INSTR_PER_SAMPLE == 12'he00; endproperty
    property p_mult; LOCKED |-> MULTIPLIER == 6'h38
        && DIVISOR inside {4'h1, 4'h2, 4'h4, 4'h6, 4'h8}; endproperty
    property p_div2; DIVIDED_REF_TICK && DIVISOR == 4'h2
        |=> !DIVIDED_REF_TICK ##1 DIVIDED_REF_TICK; endproperty
    property p_smp; SAMPLE_TICK |-> DIVIDED_REF_TICK && LOCKED; endproperty
    property p_bad; MODE_UNSUPPORTED |-> !LOCKED && !DIVIDED_REF_TICK
        && INSTR_PER_SAMPLE == 12'h000; endproperty
    property p_off; OUTPUT_CLOCK_CONFIG_PINS == BUFFERED_REFERENCE_OUT_OFF
        |=> !BUFFERED_REFERENCE_OUT; endproperty
    a_cap: assert property (p_cap) else $error("capture late");
    a_rst: assert property (p_rst) else $error("reset value");
    a_norm: assert property (p_norm) else $error("normal count");
    a_mult: assert property (p_mult) else $error("bad factor");
    a_div2: assert property (p_div2) else $error("tick period");
    a_smp: assert property (p_smp) else $error("sample tick");
    a_bad: assert property (p_bad) else $error("fault runs");
    a_off: assert property (p_off) else $error("clock out on");
endmodule

bind core_clock_pll_mode_select clock_mode_checker u_clock_mode_checker (
    .MCLK(MCLK), .NRST(NRST), .CORE_RATE_SELECT(CORE_RATE_SELECT),
    .OUTPUT_CLOCK_CONFIG_PINS(OUTPUT_CLOCK_CONFIG_PINS), .LOCKED(LOCKED),
    .MODE_UNSUPPORTED(MODE_UNSUPPORTED), .DIVISOR(DIVISOR),
    .MULTIPLIER(MULTIPLIER), .INSTR_PER_SAMPLE(INSTR_PER_SAMPLE),
    .DIVIDED_REF_TICK(DIVIDED_REF_TICK), .SAMPLE_TICK(SAMPLE_TICK),
    .BUFFERED_REFERENCE_OUT(BUFFERED_REFERENCE_OUT));

// ==== core_clock_pll_mode_select_tb.sv ====
// Bench for the core clock block with the reset and strap model.
// Assumes inputs change on the falling edge only.
`timescale 1ns/10ps
module core_clock_pll_mode_select_tb;
    import clock_mode_pkg::*;
    logic         mclk = 1'b0;
    logic         hold = 1'b1;
    logic [2:0]   code = 3'h0;
    rate_t        rate = RATE_NORMAL;
    buffered_reference_out_mode_t cfg  = BUFFERED_REFERENCE_OUT_OFF;
    rate_t        rate_pins;
    logic [2:0]   div_pins;
    logic         nrst, locked, bad, tick, stick, bout;
    logic [3:0]   divisor;
    logic [5:0]   mult;
    logic [11:0]  instr;
    int           err_total = 0, checked = 0, cycles = 0;

    reset_strap_source u_reset_strap_source (.clk(mclk), .hold(hold),
        .code(code), .rate(rate), .nrst(nrst), .div_pins(div_pins),
        .rate_pins(rate_pins));
    core_clock_pll_mode_select u_core_clock_pll_mode_select (.MCLK(mclk),
        .NRST(nrst), .DIVIDER_SELECT_PINS(div_pins),
        .CORE_RATE_SELECT(rate_pins), .OUTPUT_CLOCK_CONFIG_PINS(cfg),
        .LOCKED(locked), .MODE_UNSUPPORTED(bad), .DIVISOR(divisor),
        .MULTIPLIER(mult), .INSTR_PER_SAMPLE(instr),
        .DIVIDED_REF_TICK(tick), .SAMPLE_TICK(stick),
        .BUFFERED_REFERENCE_OUT(bout));

    // =========================================
    // Clock, watchdog and helpers
    initial begin
        forever #12.5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 60000) begin
            err_total++;
            conclude();
        end
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task conclude;
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // Reset with straps, look inside reset, wait for capture
    task restart(input logic [2:0] c, input rate_t r);
        int n;
        @(negedge mclk);
        hold <= 1'b1;
        code <= c;
        rate <= r;
        repeat (3) @(negedge mclk);
        chk({locked, mult, divisor, instr}, 32'h00001000);
        hold <= 1'b0;
        for (n = 0; n < 12 && locked !== 1'b1 && bad !== 1'b1; n++)
            @(negedge mclk);
    endtask
    // Cycles between two pulses of the tick or the sample strobe
    task gap(input bit smp, output int n);
        for (n = 0; n < 1200 && (smp ? stick : tick) !== 1'b1; n++)
            @(negedge mclk);
        n = 0;
        do begin
            @(negedge mclk);
            n++;
        end while (n < 1200 && (smp ? stick : tick) !== 1'b1);
    endtask

    // =========================================
    // Scenarios
    task automatic t_modes;
        logic [3:0]  dv [5] = '{4'h1, 4'h2, 4'h4, 4'h6, 4'h8};
        logic [11:0] ins [3] = '{12'he00, 12'h700, 12'h380};
        int          dr [3] = '{64, 32, 16};
        int          n;
        for (int r = 0; r < 3; r++) begin
            for (int c = 0; c < 5; c++) begin
                restart(3'(c), rate_t'(r));
                chk({locked, mult, divisor}, {1'b1, 6'h38, dv[c]});
                chk(16'(instr), 16'(ins[r]));
                gap(1'b0, n);
                chk(16'(n), 16'(dv[c]));
                gap(1'b1, n);
                chk(16'(n), 16'(dr[r] * dv[c]));
            end
        end
        $display("modes done");
    endtask
    task t_bad;
        int n;
        for (int c = 5; c < 9; c++) begin
            restart(3'(c), c == 8 ? RATE_BAD : RATE_NORMAL);
            n = 0;
            repeat (20) begin
                @(negedge mclk);
                n += int'(tick === 1'b1);
            end
            chk({bad, locked, instr}, 16'h2000);
            chk(16'(n), 16'h0000);
        end
        $display("unsupported done");
    endtask
    // Divide by 4 keeps the tick mode apart from the MCLK/4 mode
    task automatic t_buffered_reference_out;
        int exp [4] = '{0, 16, 8, 4};
        int n;
        logic prev;
        restart(3'h2, RATE_NORMAL);
        for (int m = 0; m < 4; m++) begin
            cfg <= buffered_reference_out_mode_t'(m);
            repeat (3) @(negedge mclk);
            prev = bout;
            n = 0;
            repeat (16) begin
                @(negedge mclk);
                n += int'(bout !== prev);
                prev = bout;
            end
            chk(16'(n), 16'(exp[m]));
        end
        $display("clock out done");
    endtask

    initial begin
        repeat (16) @(negedge mclk);
        t_modes();
        t_bad();
        t_buffered_reference_out();
        conclude();
    end
endmodule
